// ==== include/thermal_window_consts.vh ====
// constants for the thermal window and alert logic
// assumes the register select codes of the two-wire front end
`ifndef THERMAL_WINDOW_CONSTS_VH
`define THERMAL_WINDOW_CONSTS_VH

// register select codes
`define SEL_TEMP        3'h0
`define SEL_CONFIG      3'h1
`define SEL_HYST        3'h2
`define SEL_CRITICAL_EXCEEDED_FLAG        3'h3
`define SEL_LOW         3'h4
`define SEL_HIGH        3'h5
`define SEL_MAKER       3'h7

// configuration bit positions
`define CFG_EVENT_BIT   1
`define CFG_QUEUE_BIT   4

// setpoint field layout
`define SP_VALUE_MSB    15
`define SP_VALUE_LSB    3

// setpoint reset values (2, 10, 64, 80 degrees in the upper 13 bits)
`define RST_HYST        16'h0100
`define RST_LOW         16'h0500
`define RST_HIGH        16'h2000
`define RST_CRITICAL_EXCEEDED_FLAG        16'h2800

// consecutive faults needed with the queue on, and with it off
`define FAULTS_QUEUED   3'h4
`define FAULTS_SINGLE   3'h1

// arbitrary neutral identification value
`define MAKER_ID_VALUE  16'h5a3c

`endif

// ==== verilog/thermal_window_alert_logic.v ====
// threshold, hysteresis and alert logic of the temperature sensor
// assumes a front end on clk that decodes bus frames into select, write and read strobes
// outputs are active high; polarity and open-drain drive sit outside the block
//
// Behaviour
// R1: each setpoint is 16 bits with a signed 13-bit threshold in bits 15..3 and bits 2..0 meaningless.
// R2: release points are upper and critical limits minus hysteresis, and lower limit plus hysteresis.
// R3: the host keeps setpoints far enough apart that their hysteresis bands do not overlap.
// R4: a read-only 16-bit identification register returns a fixed code and ignores writes.
// R5: the window interrupt asserts when temperature crosses the upper or lower window limit.
// R6: status flags record whether the upper or the lower limit was exceeded.
// R7: in event mode a return into the window after reprogrammed limits raises another interrupt.
// R8: in comparator mode the interrupt drops once temperature is back in the window.
// R9: in event mode an asserted interrupt stays until the host reads the device.
// R10: above the critical limit a separate critical alarm output asserts.
// R11: the host services the interrupt, reads the flags and rewrites the window around the temperature.
// R12: configuration bit 1 selects comparator mode at 0 and event mode at 1, comparator after reset.
// R13: in event mode any host read clears the window interrupt.
// R14: with the fault queue on, four consecutive faults are needed before flags and outputs set.
// R15: the temperature result carries critical, upper and lower flags in bits 2, 1 and 0.
// R16: comparisons are signed 13-bit and evaluated after every completed conversion.
// R17: the critical alarm is comparator only and drops below the critical limit minus hysteresis.
`timescale 1ns/1ns
`include "thermal_window_consts.vh"

module thermal_window_alert_logic #(
  parameter [15:0] MAKER_ID = `MAKER_ID_VALUE
) (
  input  wire        clk,
  input  wire        rst_b,
  input  wire        conv_done,
  input  wire [12:0] conv_temp,
  input  wire [2:0]  reg_sel,
  input  wire        reg_wr,
  input  wire [15:0] reg_wdata,
  input  wire        reg_rd,
  output reg  [15:0] reg_rdata,
  output reg         int_out,
  output reg         critical_alarm_out
);

  // setpoints and mode bits written by the host
  reg  [15:0] hysteresis_setpoint;
  reg  [15:0] lower_window_limit;
  reg  [15:0] upper_window_limit;
  reg  [15:0] critical_limit_value;
  reg         event_mode;
  reg         queue_enable;
  reg  [12:0] last_temp;
  reg  [1:0]  window_seen;
  wire [2:0]  flag;
  wire [2:0]  cond_set;
  wire [2:0]  cond_clr;
  reg         next_int;
  reg  [15:0] next_rdata;

  // sign-extended threshold field of a setpoint
  function [13:0] limit_of;
    input [15:0] sp;
    begin
      limit_of = {sp[`SP_VALUE_MSB], sp[`SP_VALUE_MSB:`SP_VALUE_LSB]}; // [R1] [R16]
    end
  endfunction

  // stored form of a setpoint write; low bits kept at zero since they mean nothing
  function [15:0] masked_setpoint;
    input [15:0] wd;
    begin
      masked_setpoint = {wd[`SP_VALUE_MSB:`SP_VALUE_LSB], 3'b000}; // [R1]
    end
  endfunction

  // one extra bit so limit plus or minus hysteresis cannot wrap
  wire signed [13:0] temp_s   = {conv_temp[12], conv_temp};
  wire signed [13:0] hyst_s   = limit_of(hysteresis_setpoint);
  wire signed [13:0] low_s    = limit_of(lower_window_limit);
  wire signed [13:0] high_s   = limit_of(upper_window_limit);
  wire signed [13:0] critical_exceeded_flag_s   = limit_of(critical_limit_value);
  wire signed [13:0] high_rel = high_s - hyst_s; // [R2]
  wire signed [13:0] critical_exceeded_flag_rel = critical_exceeded_flag_s - hyst_s; // [R2]
  wire signed [13:0] low_rel  = low_s + hyst_s;  // [R2]

  // set and release points sit a hysteresis band apart so a reading on a limit cannot chatter
  assign cond_set[2] = temp_s > critical_exceeded_flag_s;   // [R10] [R16]
  assign cond_clr[2] = temp_s < critical_exceeded_flag_rel; // [R17]
  assign cond_set[1] = temp_s > high_s;   // [R5] [R16]
  assign cond_clr[1] = temp_s < high_rel;
  assign cond_set[0] = temp_s < low_s;    // [R5] [R16]
  assign cond_clr[0] = temp_s > low_rel;

  wire [2:0] faults_needed = queue_enable ? `FAULTS_QUEUED : `FAULTS_SINGLE;

  // one fault counter and flag per limit; only setting is queued, release is immediate
  // counters saturate so a long fault run cannot wrap back below the queue depth
  genvar i;
  generate
    for (i = 0; i < 3; i = i + 1) begin : limit_track
      reg [1:0] fault_cnt;
      reg       hit;
      wire      enough = ({1'b0, fault_cnt} + 3'h1) >= faults_needed;
      always @(posedge clk) begin
        if (!rst_b) begin
          fault_cnt <= 2'h0;
          hit       <= 1'b0;
        end else if (conv_done) begin
          if (cond_set[i]) begin
            if (enough) begin
              hit <= 1'b1; // [R6] [R14]
            end
            if (fault_cnt != 2'h3) begin
              fault_cnt <= fault_cnt + 2'h1;
            end
          end else begin
            fault_cnt <= 2'h0; // [R14]
            if (cond_clr[i]) begin
              hit <= 1'b0;
            end
          end
        end
      end
      assign flag[i] = hit;
    end
  endgenerate

  // register writes
  always @(posedge clk) begin
    if (!rst_b) begin
      hysteresis_setpoint  <= `RST_HYST;
      lower_window_limit   <= `RST_LOW;
      upper_window_limit   <= `RST_HIGH;
      critical_limit_value <= `RST_CRITICAL_EXCEEDED_FLAG;
      event_mode           <= 1'b0; // [R12]
      queue_enable         <= 1'b0;
    end else if (reg_wr) begin
      case (reg_sel)
        `SEL_CONFIG: begin
          event_mode   <= reg_wdata[`CFG_EVENT_BIT]; // [R12]
          queue_enable <= reg_wdata[`CFG_QUEUE_BIT];
        end
        `SEL_HYST: begin
          hysteresis_setpoint <= masked_setpoint(reg_wdata); // [R1]
        end
        `SEL_CRITICAL_EXCEEDED_FLAG: begin
          critical_limit_value <= masked_setpoint(reg_wdata); // [R1]
        end
        `SEL_LOW: begin
          lower_window_limit <= masked_setpoint(reg_wdata); // [R1]
        end
        `SEL_HIGH: begin
          upper_window_limit <= masked_setpoint(reg_wdata); // [R1]
        end
        default: begin
          // temperature and identification are read only
          event_mode <= event_mode; // [R4]
        end
      endcase
    end
  end

  // result kept between conversions so host reads stay steady
  always @(posedge clk) begin
    if (!rst_b) begin
      last_temp <= 13'h0000;
    end else if (conv_done) begin
      last_temp <= conv_temp;
    end
  end

  // window interrupt; in event mode any change of the window flags is an event
  wire window_changed = flag[1:0] != window_seen;
  // window_seen lags the flags by one cycle, so each change is seen at one edge only

  always @* begin
    if (event_mode) begin
      // a new event in the read cycle wins over the clear
      next_int = window_changed | (int_out & ~reg_rd); // [R7] [R9] [R13]
    end else begin
      next_int = flag[1] | flag[0]; // [R5] [R8]
    end
  end

  always @* begin
    case (reg_sel)
      `SEL_TEMP:   next_rdata = {last_temp, flag}; // [R15]
      `SEL_CONFIG: next_rdata = {11'h000, queue_enable, 2'b00, event_mode, 1'b0};
      `SEL_HYST:   next_rdata = hysteresis_setpoint;
      `SEL_CRITICAL_EXCEEDED_FLAG:   next_rdata = critical_limit_value;
      `SEL_LOW:    next_rdata = lower_window_limit;
      `SEL_HIGH:   next_rdata = upper_window_limit;
      `SEL_MAKER:  next_rdata = MAKER_ID; // [R4]
      // unused select reads as zero
      default:     next_rdata = 16'h0000;
    endcase
  end

  always @(posedge clk) begin
    if (!rst_b) begin
      window_seen <= 2'b00;
      int_out     <= 1'b0;
    end else begin
      window_seen <= flag[1:0];
      int_out     <= next_int;
    end
  end

  // critical alarm is a plain comparator, never latched by reads
  always @(posedge clk) begin
    if (!rst_b) begin
      critical_alarm_out <= 1'b0;
    end else begin
      critical_alarm_out <= flag[2]; // [R10] [R17]
    end
  end

  // readback refreshed every cycle so it follows reg_sel one cycle late
  always @(posedge clk) begin
    if (!rst_b) begin
      reg_rdata <= 16'h0000;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

endmodule

// ==== verification/alert_chk.sv ====
// port checker for the alert logic
// assumes bind onto the block, one clock
`timescale 1ns/1ns
module alert_chk #(
  parameter [15:0] MAKER_ID = 16'h5a3c
) (
  input wire        clk,
  input wire        rst_b,
  input wire        conv_done,
  input wire [12:0] conv_temp,
  input wire [2:0]  reg_sel,
  input wire        reg_wr,
  input wire [15:0] reg_wdata,
  input wire        reg_rd,
  input wire [15:0] reg_rdata,
  input wire        int_out,
  input wire        critical_alarm_out
);
  reg [15:0] sp [2:5];
  reg        ev, q;
  wire signed [12:0] t = conv_temp, hy = sp[2][15:3], cr = sp[3][15:3], lo = sp[4][15:3], hi = sp[5][15:3];
  // shadow only; limits must not move within two cycles of a conversion
  always @(posedge clk) begin
    if (!rst_b) begin
      sp[2] <= 16'h0100; sp[3] <= 16'h2800; sp[4] <= 16'h0500; sp[5] <= 16'h2000; ev <= 1'b0; q <= 1'b0;
    end else if (reg_wr && reg_sel == 3'h1) begin
      {q, ev} <= {reg_wdata[4], reg_wdata[1]};
    end else if (reg_wr && reg_sel > 3'h1 && reg_sel < 3'h6) begin
      sp[reg_sel] <= reg_wdata;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_id_fixed: assert property ($past(rst_b) && $past(reg_sel) == 3'h7 |-> reg_rdata == MAKER_ID)
    else $error("id wrong");
  a_sp_low: assert property ($past(rst_b) && $past(reg_sel) inside {[3'h2:3'h5]} |-> reg_rdata[2:0] == 3'h0)
    else $error("low bits");
  a_critical_exceeded_flag_set: assert property (conv_done && t > cr && !q |-> ##2 critical_alarm_out)
    else $error("critical_exceeded_flag set");
  a_critical_exceeded_flag_rel: assert property (conv_done && t < cr - hy |-> ##2 !critical_alarm_out)
    else $error("critical_exceeded_flag release");
  a_win_set: assert property (conv_done && (t > hi || t < lo) && !q && !ev |-> ##2 int_out)
    else $error("int set");
  a_win_rel: assert property (conv_done && t < hi - hy && t > lo + hy && !ev |-> ##2 !int_out)
    else $error("int release");
  a_ev_hold: assert property (ev && int_out && !reg_rd && !reg_wr |=> int_out)
    else $error("event dropped");
  a_ev_clear: assert property (ev && reg_rd && !reg_wr && !conv_done && !$past(conv_done)
    && !$past(conv_done, 2) && !$past(conv_done, 3) |=> !int_out) else $error("read kept int");
  c_critical_exceeded_flag: cover property (critical_alarm_out);
  c_ev: cover property (ev && $fell(int_out));
  c_q: cover property (q && $rose(int_out));
endmodule
bind thermal_window_alert_logic alert_chk #(
  .MAKER_ID(MAKER_ID)
) alert_chk_inst (
  .clk                (clk),
  .rst_b              (rst_b),
  .conv_done          (conv_done),
  .conv_temp          (conv_temp),
  .reg_sel            (reg_sel),
  .reg_wr             (reg_wr),
  .reg_wdata          (reg_wdata),
  .reg_rd             (reg_rd),
  .reg_rdata          (reg_rdata),
  .int_out            (int_out),
  .critical_alarm_out (critical_alarm_out)
);

// ==== verification/host.sv ====
// host controller model: register writes and reads
// assumes the block's clock; drives 1 ns after the edge
`timescale 1ns/1ns
module host (
  input  wire        clk,
  input  wire [15:0] reg_rdata,
  output reg  [2:0]  reg_sel,
  output reg         reg_wr,
  output reg         reg_rd,
  output reg  [15:0] reg_wdata
);
  initial begin reg_sel = 3'h0; reg_wr = 1'b0; reg_rd = 1'b0; reg_wdata = 16'h0000; end
  // callers keep limit bands apart and rewrite the window around the temperature
  task wr(input [2:0] s, input [15:0] v);
    begin
      @(posedge clk) #1 reg_sel = s; reg_wdata = v; reg_wr = 1'b1;
      @(posedge clk) #1 reg_wr = 1'b0; reg_wdata = ~v;
    end
  endtask
  task rd(input [2:0] s, output [15:0] d);
    begin
      @(posedge clk) #1 reg_sel = s;
      @(posedge clk) #1 d = reg_rdata; reg_rd = 1'b1;
      @(posedge clk) #1 reg_rd = 1'b0;
    end
  endtask
endmodule

// ==== verification/thermal_window_alert_logic_test.sv ====
// top bench for the alert logic
// assumes the host model drives the register port
`timescale 1ns/1ns
module thermal_window_alert_logic_test;
  reg         clk = 0, rst_b = 0, conv_done = 0;
  reg [12:0]  conv_temp = 13'h0000;
  wire [2:0]  reg_sel;
  wire        reg_wr, reg_rd, int_out, critical_alarm_out;
  wire [15:0] reg_wdata, reg_rdata;
  reg [15:0]  d;
  integer     n_mismatch = 0, total_checks = 0, cyc = 0;
  thermal_window_alert_logic thermal_window_alert_logic_inst (
    .clk                (clk),
    .rst_b              (rst_b),
    .conv_done          (conv_done),
    .conv_temp          (conv_temp),
    .reg_sel            (reg_sel),
    .reg_wr             (reg_wr),
    .reg_wdata          (reg_wdata),
    .reg_rd             (reg_rd),
    .reg_rdata          (reg_rdata),
    .int_out            (int_out),
    .critical_alarm_out (critical_alarm_out)
  );
  host host_inst (
    .clk       (clk),
    .reg_rdata (reg_rdata),
    .reg_sel   (reg_sel),
    .reg_wr    (reg_wr),
    .reg_rd    (reg_rd),
    .reg_wdata (reg_wdata)
  );
  initial forever #50 clk = ~clk;
  always @(posedge clk) begin cyc = cyc + 1; if (cyc == 3000) begin n_mismatch = n_mismatch + 1; results; end end
  task results;
    begin
      $display("mismatches %0d checks %0d", n_mismatch, total_checks);
      if (n_mismatch == 0 && total_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  task chk(input [15:0] g, e);
    begin
      total_checks = total_checks + 1;
      if (g !== e) begin n_mismatch = n_mismatch + 1; $display("[ERR] %0t got %h exp %h", $time, g, e); end
    end
  endtask
  // one conversion; temp line goes to the inverse once it is no longer valid
  task cv(input [12:0] t);
    begin
      @(posedge clk) #1 conv_temp = t; conv_done = 1;
      @(posedge clk) #1 conv_done = 0; conv_temp = ~t;
      repeat (3) @(posedge clk);
      #1;
    end
  endtask
  task t_regs;
    begin
      host_inst.rd(3'h2, d); chk(d, 16'h0100);
      host_inst.wr(3'h4, 16'h1237); host_inst.rd(3'h4, d); chk(d, 16'h1230);
      host_inst.wr(3'h7, 16'h0000); host_inst.rd(3'h7, d); chk(d, 16'h5a3c);
      host_inst.wr(3'h2, 16'h0107); host_inst.rd(3'h2, d); chk(d, 16'h0100);
      host_inst.wr(3'h3, 16'h2807); host_inst.rd(3'h3, d); chk(d, 16'h2800);
      host_inst.wr(3'h5, 16'h2005); host_inst.rd(3'h5, d); chk(d, 16'h2000);
      host_inst.wr(3'h1, 16'h00ff); host_inst.rd(3'h1, d); chk(d, 16'h0012);
      host_inst.wr(3'h1, 16'h0000);
      host_inst.wr(3'h4, 16'h0500);
    end
  endtask
  task t_comp;
    begin
      cv(13'h0410); host_inst.rd(3'h0, d); chk(d, 16'h2082);
      cv(13'h03f0); chk(int_out, 1'h1);
      cv(13'h03c0); chk(int_out, 1'h0);
      cv(13'h0090); host_inst.rd(3'h0, d); chk(d, 16'h0481);
      cv(13'h1e70); host_inst.rd(3'h0, d); chk(d, 16'hf381);
      cv(13'h0510); chk({int_out, critical_alarm_out}, 2'h3);
      cv(13'h04f0); chk(critical_alarm_out, 1'h1);
      cv(13'h04c0); chk({int_out, critical_alarm_out}, 2'h2);
      cv(13'h0100);
    end
  endtask
  task t_event;
    begin
      host_inst.wr(3'h1, 16'h0002); cv(13'h0410);
      repeat (4) @(posedge clk); #1 chk(int_out, 1'h1);
      host_inst.rd(3'h0, d); chk(int_out, 1'h0);
      host_inst.wr(3'h5, 16'h2400); cv(13'h0410); chk(int_out, 1'h1);
      host_inst.rd(3'h0, d); chk(d, 16'h2080);
    end
  endtask
  task t_queue;
    begin
      host_inst.wr(3'h1, 16'h0010);
      repeat (3) cv(13'h0500); chk(int_out, 1'h0);
      cv(13'h0500); chk(int_out, 1'h1);
      host_inst.wr(3'h1, 16'h0000); cv(13'h0100); chk(int_out, 1'h0);
    end
  endtask
  initial begin
    repeat (20) @(posedge clk);
    #1 rst_b = 1;
    chk({int_out, critical_alarm_out}, 2'h0);
    t_regs; t_comp; t_event; t_queue;
    results;
  end
endmodule
